// ==== rtl/gain_range_consts.svh ====
// Register offsets, field positions, reset values for the gain-ranging block.
// Assumes a 32-bit AXI4-Lite slave with byte addresses.
//
// Operation
// - With enable set, 3-bit gain code is driven on exponent lines.
// - Sample magnitude above upper threshold lowers gain code by one immediately.
// - Sample below lower threshold loads dwell timer from 20-bit dwell setting.
// - Timer counts down while below lower; at count 1 code rises by one.
// - Input above lower threshold before expiry abandons pending increase.
// - Gain code feeds internal exponent; each step attenuates 6.02 dB.
// - Programmable 6-bit pipeline delay, up to 63 cycles, before exponent.
// - Gain change requests during a relinearization delay are ignored.
// - 10-bit thresholds compare with 10 MSBs of input magnitude.
// - On enabling, gain code starts at 000.
`ifndef GAIN_RANGE_CONSTS_SVH
`define GAIN_RANGE_CONSTS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define GR_CTRL_OFS 8'h00
`define GR_UPPER_OFS 8'h04
`define GR_LOWER_OFS 8'h08
`define GR_DWELL_OFS 8'h0C
`define GR_STATUS_OFS 8'h10

// ----------------------------------------
// Fields
// ----------------------------------------
`define GR_CTRL_EN_BIT 0
`define GR_CTRL_DLY_LSB 8
`define GR_CTRL_DLY_MSB 13
`define GR_THR_MSB 9
`define GR_DWELL_MSB 19
`define GR_ST_CODE_LSB 0
`define GR_ST_EXP_LSB 4
`define GR_ST_DWELL_BIT 8
`define GR_ST_BUSY_BIT 9

// ----------------------------------------
// Reset values and answers
// ----------------------------------------
`define GR_CTRL_RST 32'h0000_0000
`define GR_UPPER_RST 32'h0000_03FF
`define GR_LOWER_RST 32'h0000_0000
`define GR_DWELL_RST 32'h0000_0001
`define GR_RESP_OKAY 2'h0
`define GR_RESP_SLVERR 2'h2
`define GR_CODE_MIN 3'h0
`define GR_CODE_MAX 3'h7

`endif

// ==== rtl/gain_range_pkg.sv ====
// Types shared by the gain-ranging block.
// Assumes nothing of its surroundings.
package gain_range_pkg;

    typedef logic [2:0] gain_code_t;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_COMPARE,
        ST_DWELL
    } gain_state_e;

endpackage

// ==== rtl/gain_delay_line.sv ====
// Programmable-length delay line for the gain code.
// Assumes one sample per clock; delay is steady while a change is in flight.
`timescale 1ns/10ps
module gain_delay_line #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 63,
    parameter int SEL_W = 6
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [SEL_W-1:0] delay_i,
    input wire logic [WIDTH-1:0] data_i,
    output logic [WIDTH-1:0] data_o
);

    logic [WIDTH-1:0] stage_r [DEPTH];
    logic [WIDTH-1:0] stage_nxt [DEPTH];

    // ----------------------------------------
    // Shift
    // ----------------------------------------
    always_comb begin
        stage_nxt[0] = data_i;
        for (int i = 1; i < DEPTH; i++) begin
            stage_nxt[i] = stage_r[i-1];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (!rst_n_i) begin
                stage_r[i] <= '0;
            end else begin
                stage_r[i] <= stage_nxt[i];
            end
        end
    end

    // ----------------------------------------
    // Tap select
    // ----------------------------------------
    // zero taps bypass
    always_comb begin
        if (delay_i == '0) begin
            data_o = data_i;
        end else begin
            data_o = stage_r[delay_i - SEL_W'(1)];
        end
    end

endmodule

// ==== rtl/gain_range_ctrl.sv ====
// Automatic gain-ranging control with AXI4-Lite setup registers.
// Assumes one input sample per ref_clk_i cycle, synchronous to it.
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "gain_range_consts.svh"
module gain_range_ctrl #(
    parameter int SAMPLE_W = 14,
    parameter int DLY_W = 6,
    parameter int DLY_MAX = 63,
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [SAMPLE_W-1:0] sample_i,
    input wire logic [2:0] gain_exponent_lines_i,
    output logic [2:0] gain_exponent_lines_o,
    output logic gain_exponent_lines_oe_n_o,
    output logic [2:0] exponent_o,
    output logic [SAMPLE_W-1:0] relin_data_o,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [31:0] ctrl_r, ctrl_nxt, upper_r, upper_nxt;
    logic [31:0] lower_r, lower_nxt, dwell_r, dwell_nxt;
    logic do_write;

    gain_range_pkg::gain_state_e state_r, state_nxt;
    gain_range_pkg::gain_code_t code_r, code_nxt;
    logic [19:0] timer_r, timer_nxt;
    logic [DLY_W-1:0] busy_r, busy_nxt;
    logic [SAMPLE_W-1:0] mag;
    logic [9:0] mag_top;
    logic over, under, enable;
    logic [DLY_W-1:0] delay;
    gain_range_pkg::gain_code_t code_dly;

    logic [2:0] exp_r, exp_nxt, pin_r, pin_nxt;
    logic oe_n_r, oe_n_nxt;
    logic [SAMPLE_W-1:0] data_r, data_nxt;

    // Merge a write into a register under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return res;
    endfunction

    // ----------------------------------------
    // AXI4-Lite write and read channels
    // ----------------------------------------
    always_comb begin
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        aw_have_nxt = aw_have_r;
        w_have_nxt = w_have_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        do_write = 1'b0;
        if (s_axi_awvalid && awready_r) begin
            awaddr_nxt = s_axi_awaddr;
            aw_have_nxt = 1'b1;
        end
        if (s_axi_wvalid && wready_r) begin
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
            w_have_nxt = 1'b1;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        // Both halves in hand and no response pending
        if (aw_have_r && w_have_r && !bvalid_r) begin
            do_write = 1'b1;
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            case (awaddr_r)
                `GR_CTRL_OFS, `GR_UPPER_OFS, `GR_LOWER_OFS, `GR_DWELL_OFS,
                `GR_STATUS_OFS: bresp_nxt = `GR_RESP_OKAY;
                default: bresp_nxt = `GR_RESP_SLVERR;
            endcase
        end
        awready_nxt = !aw_have_nxt && !bvalid_nxt;
        wready_nxt = !w_have_nxt && !bvalid_nxt;

        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `GR_RESP_OKAY;
            case (s_axi_araddr)
                `GR_CTRL_OFS: rdata_nxt = ctrl_r;
                `GR_UPPER_OFS: rdata_nxt = upper_r;
                `GR_LOWER_OFS: rdata_nxt = lower_r;
                `GR_DWELL_OFS: rdata_nxt = dwell_r;
                `GR_STATUS_OFS: begin
                    rdata_nxt = '0;
                    rdata_nxt[`GR_ST_CODE_LSB +: 3] = code_r;
                    rdata_nxt[`GR_ST_EXP_LSB +: 3] = exp_r;
                    rdata_nxt[`GR_ST_DWELL_BIT] = (state_r == gain_range_pkg::ST_DWELL);
                    rdata_nxt[`GR_ST_BUSY_BIT] = (busy_r != '0);
                end
                default: begin
                    rdata_nxt = '0;
                    rresp_nxt = `GR_RESP_SLVERR;
                end
            endcase
        end
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `GR_RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= `GR_RESP_OKAY;
        end else begin
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // ----------------------------------------
    // Setup registers
    // ----------------------------------------
    // Unused bits masked so readback shows only real fields
    always_comb begin
        ctrl_nxt = ctrl_r;
        upper_nxt = upper_r;
        lower_nxt = lower_r;
        dwell_nxt = dwell_r;
        if (do_write) begin
            case (awaddr_r)
                `GR_CTRL_OFS: ctrl_nxt = merge(ctrl_r, wdata_r, wstrb_r) & 32'h0000_3F01;
                `GR_UPPER_OFS: upper_nxt = merge(upper_r, wdata_r, wstrb_r) & 32'h0000_03FF;
                `GR_LOWER_OFS: lower_nxt = merge(lower_r, wdata_r, wstrb_r) & 32'h0000_03FF;
                `GR_DWELL_OFS: dwell_nxt = merge(dwell_r, wdata_r, wstrb_r) & 32'h000F_FFFF;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ctrl_r <= `GR_CTRL_RST;
            upper_r <= `GR_UPPER_RST;
            lower_r <= `GR_LOWER_RST;
            dwell_r <= `GR_DWELL_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            upper_r <= upper_nxt;
            lower_r <= lower_nxt;
            dwell_r <= dwell_nxt;
        end
    end

    // ----------------------------------------
    // Magnitude and comparison
    // ----------------------------------------
    assign enable = ctrl_r[`GR_CTRL_EN_BIT];
    assign delay = ctrl_r[`GR_CTRL_DLY_MSB:`GR_CTRL_DLY_LSB];
    // Most negative sample folds to full scale, still fits unsigned
    assign mag = sample_i[SAMPLE_W-1] ? SAMPLE_W'(-sample_i) : sample_i;
    assign mag_top = mag[SAMPLE_W-1 -: 10];
    assign over = mag_top > upper_r[`GR_THR_MSB:0];
    assign under = mag_top < lower_r[`GR_THR_MSB:0];

    // ----------------------------------------
    // Gain stepping
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        code_nxt = code_r;
        timer_nxt = timer_r;
        busy_nxt = (busy_r != '0) ? busy_r - DLY_W'(1) : busy_r;
        case (state_r)
            gain_range_pkg::ST_OFF: begin
                code_nxt = `GR_CODE_MIN;
                busy_nxt = '0;
                timer_nxt = '0;
                if (enable) begin
                    state_nxt = gain_range_pkg::ST_COMPARE;
                end
            end
            gain_range_pkg::ST_COMPARE, gain_range_pkg::ST_DWELL: begin
                if (over) begin
                    state_nxt = gain_range_pkg::ST_COMPARE;
                    if (busy_r == '0 && code_r != `GR_CODE_MIN) begin
                        code_nxt = code_r - 3'h1;
                        busy_nxt = delay;
                    end
                end else if (under) begin
                    if (state_r == gain_range_pkg::ST_COMPARE) begin
                        timer_nxt = dwell_r[`GR_DWELL_MSB:0];
                        state_nxt = gain_range_pkg::ST_DWELL;
                    end else if (timer_r <= 20'h1) begin
                        state_nxt = gain_range_pkg::ST_COMPARE;
                        if (busy_r == '0 && code_r != `GR_CODE_MAX) begin
                            code_nxt = code_r + 3'h1;
                            busy_nxt = delay;
                        end
                    end else begin
                        timer_nxt = timer_r - 20'h1;
                    end
                end else begin
                    state_nxt = gain_range_pkg::ST_COMPARE;
                end
                if (!enable) begin
                    state_nxt = gain_range_pkg::ST_OFF;
                end
            end
            default: state_nxt = gain_range_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_r <= gain_range_pkg::ST_OFF;
            code_r <= `GR_CODE_MIN;
            timer_r <= '0;
            busy_r <= '0;
        end else begin
            state_r <= state_nxt;
            code_r <= code_nxt;
            timer_r <= timer_nxt;
            busy_r <= busy_nxt;
        end
    end

    // ----------------------------------------
    // Relinearization path
    // ----------------------------------------
    // match external settling delay; flushed while off, so no stale code
    gain_delay_line #(
        .WIDTH(3),
        .DEPTH(DLY_MAX),
        .SEL_W(DLY_W)
    ) u_delay (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i && enable),
        .delay_i(delay),
        .data_i(code_r),
        .data_o(code_dly)
    );

    always_comb begin
        pin_nxt = code_nxt;
        oe_n_nxt = !(state_nxt != gain_range_pkg::ST_OFF);
        // delayed code is the exponent; pins feed it when disabled
        exp_nxt = enable ? code_dly : gain_exponent_lines_i;
        // each exponent step halves, 6.02 dB
        data_nxt = SAMPLE_W'($signed(sample_i) >>> exp_nxt);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pin_r <= `GR_CODE_MIN;
            oe_n_r <= 1'b1;
            exp_r <= '0;
            data_r <= '0;
        end else begin
            pin_r <= pin_nxt;
            oe_n_r <= oe_n_nxt;
            exp_r <= exp_nxt;
            data_r <= data_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign gain_exponent_lines_o = pin_r;
    assign gain_exponent_lines_oe_n_o = oe_n_r;
    assign exponent_o = exp_r;
    assign relin_data_o = data_r;
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rvalid = rvalid_r;

endmodule

// ==== sim/gain_range_ctrl_monitor.sv ====
// Checker for the gain-ranging block, port relations only.
// Assumes the top module's ports and one clock domain.
`timescale 1ns/10ps
module gain_range_ctrl_monitor #(
    parameter int SAMPLE_W = 14
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [SAMPLE_W-1:0] sample_i,
    input wire logic [2:0] gain_exponent_lines_o,
    input wire logic gain_exponent_lines_oe_n_o,
    input wire logic [2:0] exponent_o,
    input wire logic [SAMPLE_W-1:0] relin_data_o,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    logic [2:0] pin;
    logic oe_n;
    assign pin = gain_exponent_lines_o;
    assign oe_n = gain_exponent_lines_oe_n_o;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_step;
        !oe_n && !$past(oe_n) |-> (pin == $past(pin)) || (pin == $past(pin) + 3'h1)
            || (pin == $past(pin) - 3'h1);
    endproperty
    a_step: assert property (p_step) else $error("gain code jumped");

    property p_nowrap;
        !oe_n && !$past(oe_n) |-> !($past(pin) == 3'h7 && pin == 3'h0)
            && !($past(pin) == 3'h0 && pin == 3'h7);
    endproperty
    a_nowrap: assert property (p_nowrap) else $error("gain code wrapped");

    property p_start;
        $fell(oe_n) |-> pin == 3'h0;
    endproperty
    a_start: assert property (p_start) else $error("code not zero on enable");

    property p_relin;
        $past(rst_n_i) |->
            relin_data_o == SAMPLE_W'($signed($past(sample_i)) >>> exponent_o);
    endproperty
    a_relin: assert property (p_relin) else $error("relinearized data wrong");

    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");

    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");

    property p_blat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_blat: assert property (p_blat) else $error("write response timing");

    property p_rlat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rlat: assert property (p_rlat) else $error("read response timing");

    c_top: cover property (pin == 3'h7 && !oe_n);
    c_down: cover property (!oe_n && $past(pin) == 3'h1 && pin == 3'h0);
    c_on: cover property ($fell(oe_n));
endmodule

bind gain_range_ctrl gain_range_ctrl_monitor #(.SAMPLE_W(SAMPLE_W)) mon (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sample_i(sample_i),
    .gain_exponent_lines_o(gain_exponent_lines_o),
    .gain_exponent_lines_oe_n_o(gain_exponent_lines_oe_n_o),
    .exponent_o(exponent_o), .relin_data_o(relin_data_o),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ==== sim/gain_stage_model.sv ====
// Behavioural model of the external gain-ranging amplifier.
// Assumes the bench resolves the exponent pins before they reach it.
`timescale 1ns/10ps
module gain_stage_model #(
    parameter int W = 14
) (
    input wire logic ref_clk_i,
    input wire logic signed [W-1:0] amp_i,
    input wire logic [2:0] pins_i,
    output logic [W-1:0] sample_o
);
    // ----------------------------------------
    // Gain stage
    // ----------------------------------------
    int lim;
    int boost;
    always_comb begin
        lim = (1 << (W - 1)) - 1;
        boost = int'(amp_i) <<< pins_i;
        if (boost > lim) boost = lim;
        if (boost < -lim) boost = -lim;
    end
    // Clips at full scale, as the converter would
    initial sample_o = '0;
    always @(posedge ref_clk_i) begin
        sample_o <= W'(boost);
    end
endmodule

// ==== sim/gain_range_ctrl_tb.sv ====
// Self-checking bench for the gain-ranging block.
// Assumes gain_stage_model stands in for the external amplifier.
`timescale 1ns/10ps
module gain_range_ctrl_tb;
    // ----------------------------------------
    // Bench signals
    // ----------------------------------------
    logic clk = 1'b0, rst_n = 1'b0;
    logic signed [13:0] amp = 14'sh0;
    logic [13:0] smp, relin;
    logic [2:0] ext_exp = 3'h5, pins_o, pins, expo;
    logic oe_n, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [1:0] bresp, rresp;
    int mismatches = 0, n_checks = 0;

    // Released pins carry what the bench drives in the far side's place
    assign pins = oe_n ? ext_exp : pins_o;
    initial begin
        forever #12.5 clk = ~clk;
    end

    gain_range_ctrl dut (.ref_clk_i(clk), .rst_n_i(rst_n), .sample_i(smp),
        .gain_exponent_lines_i(pins), .gain_exponent_lines_o(pins_o),
        .gain_exponent_lines_oe_n_o(oe_n), .exponent_o(expo), .relin_data_o(relin),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    gain_stage_model amp_model (.ref_clk_i(clk), .amp_i(amp), .pins_i(pins), .sample_o(smp));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        if (mismatches == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Response ready raised only once the answer shows, to exercise holding
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                bready <= 1'b0;
                check(32'(bresp), 32'(er));
                done = 1'b1;
            end else if (bvalid) bready <= 1'b1;
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic done;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rready <= 1'b0;
                check(rdata, ed);
                check(32'(rresp), 32'(er));
                done = 1'b1;
            end else if (rvalid) rready <= 1'b1;
        end
    endtask

    task automatic cfg(input logic [9:0] lo, input logic [9:0] up, input logic [19:0] dw,
        input logic [5:0] dly);
        amp <= 14'sh0200;
        axi_wr(8'h00, 32'h0, 2'h0);
        axi_wr(8'h04, 32'(up), 2'h0);
        axi_wr(8'h08, 32'(lo), 2'h0);
        axi_wr(8'h0C, 32'(dw), 2'h0);
        axi_wr(8'h00, {18'h0, dly, 8'h01}, 2'h0);
        repeat (3) @(posedge clk);
        check(32'(oe_n), 32'h0);
        check(32'(pins_o), 32'h0);
    endtask

    task automatic t_regs;
        axi_rd(8'h00, 32'h0, 2'h0);
        axi_rd(8'h04, 32'h3FF, 2'h0);
        axi_rd(8'h08, 32'h0, 2'h0);
        axi_rd(8'h0C, 32'h1, 2'h0);
        axi_rd(8'h14, 32'h0, 2'h2);
        axi_wr(8'h14, 32'hFFFF_FFFF, 2'h2);
        axi_wr(8'h10, 32'hFFFF_FFFF, 2'h0);
        axi_rd(8'h10, 32'h50, 2'h0);
        axi_wr(8'h0C, 32'hFFFF_FFFF, 2'h0);
        axi_rd(8'h0C, 32'h000F_FFFF, 2'h0);
        check(32'(oe_n), 32'h1);
        check(32'(expo), 32'h5);
    endtask

    task automatic t_dwell;
        int c;
        cfg(10'h010, 10'h180, 20'd20, 6'd0);
        repeat (4) begin
            amp <= 14'sh0;
            repeat (18) @(posedge clk);
            amp <= 14'sh0200;
            @(posedge clk);
        end
        check(32'(pins_o), 32'h0);
        amp <= 14'sh0;
        c = 0;
        while (pins_o === 3'h0 && c < 40) begin
            @(posedge clk);
            c++;
        end
        check(32'(c >= 20 && c <= 26), 32'h1);
        repeat (200) @(posedge clk);
        check(32'(pins_o), 32'h7);
        // Loop lag overshoots one step; this level settles at code 1
        amp <= 14'sh0400;
        c = 0;
        while (pins_o === 3'h7 && c < 9) begin
            @(posedge clk);
            c++;
        end
        check(32'(c <= 5), 32'h1);
        repeat (30) @(posedge clk);
        check(32'(pins_o), 32'h1);
        // Boundary on the ten upper magnitude bits, negative side
        amp <= -14'sh0C07;
        repeat (10) @(posedge clk);
        check(32'(pins_o), 32'h1);
        check(32'(expo), 32'h1);
        check(32'(relin), 32'h33F9);
        amp <= -14'sh0C08;
        repeat (8) @(posedge clk);
        check(32'(pins_o), 32'h0);
    endtask

    task automatic t_delay;
        int c;
        int lag;
        logic [5:0] dtab [3] = '{6'd0, 6'd9, 6'd63};
        foreach (dtab[i]) begin
            cfg(10'h010, 10'h180, 20'd1, dtab[i]);
            amp <= 14'sh0;
            c = 0;
            while (pins_o === 3'h0 && c < 20) begin
                @(posedge clk);
                c++;
            end
            c = 0;
            lag = -1;
            // Exponent catches up on the edge the next step shows, one edge before it at delay 0
            while (c < 90) begin
                if (lag < 0 && expo === 3'h1) lag = c;
                if (pins_o !== 3'h1) break;
                @(posedge clk);
                c++;
            end
            check(32'(lag), 32'(dtab[i]) + 32'h1);
            check(32'(c >= dtab[i] + 1 && c <= dtab[i] + 4), 32'h1);
        end
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_dwell();
        t_delay();
        results();
    end

    // Run needs about 600 cycles; over thirty times that means a hang
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        results();
    end
endmodule
